// >>> pkg/hsfs_consts.svh
// Constants for the hot-swap fault sequencer: stage and phase counts, mode codes, widths.
// Assumes inclusion by bare name from the package and the design files.
//
// Summary of operation
// - Enable above supply lockout rising threshold; below falling threshold disable, gate low.
// - Low-supply comparator hysteretic: good above 3.225V, undervoltage below 2.925V.
// - High-supply comparator hysteretic: overvoltage above 6.150V, clears below 5.550V.
// - Low-supply input low holds block in reset, gate and timer low.
// - Rising low-supply input starts initial timing when other interlocks hold.
// - Falling low-supply input shuts down at once, gate low, power-good inactive high.
// - Overvoltage forces gate low, leaves breaker timing, power-good, cooling alone.
// - Overvoltage clearing restarts gate when interlocks except timer level hold.
// - Overvoltage resets timing capacitor only during initial timing.
// - Output-low comparator below 2.385V with gate-high comparator sets power-good.
// - Breaker fault adds eight times clamp current to 230uA fast charge.
// - Timer control picks one of four exclusive modes.
// - Reset switch after initial timing, in lockout, undervoltage, overvoltage during timing.
// - Interlocks met: release reset switch, slow charge starts initial timing.
// - Timer at 4V in initial timing: discharge, start-up, release ramp and gate.
// - Sense drop above 50mV fast-charges timer for breaker delay.
// - Sense below 50mV without shutdown slowly discharges timer.
// - Breaker charge to 4V forces gate low; latch off or start cooling.
// - Latch-off cleared by low-supply pulse, external timer pull low, lockout cycle.
// - Output below 5V makes clamp current zero; fast charge nominal only.
// - Latch-off after timeout holds timer up with slow pull-up.
// - Cooling alternates pull-down to 1V and pull-up to 4V: four down, three up.
// - At 1V ending final cooling pull-down, auto-retry attempts gate ramp-up.
// - Lockout, UV, OV watched always; sense, ramp, timer, gate checked before start. OV is not watched in latch-off or cooling.
// - During start-up power-good latches active low on gate-high and output-low.
// - Power-good cleared by lockout, undervoltage, timer at 4V; overvoltage no effect.
// - Ramp held low in lockout, UV, OV, initial timing, after breaker timeout.
`ifndef HSFS_CONSTS_SVH
`define HSFS_CONSTS_SVH
`define HSFS_SYNC_STAGES 3
`define HSFS_COOL_DOWN_PHASES 3'h4
`define HSFS_COOL_UP_PHASES 3'h3
`define HSFS_MODE_W 4
`define HSFS_MODE_SLOW_UP 4'h1
`define HSFS_MODE_FAST_UP 4'h2
`define HSFS_MODE_SLOW_DN 4'h4
`define HSFS_MODE_RESET 4'h8
`define HSFS_IN_W 10
`endif

// >>> pkg/hsfs_pkg.sv
// Types for the hot-swap fault sequencer.
// Assumes hsfs_consts.svh is reachable on the include path.
`default_nettype none
`include "hsfs_consts.svh"
package hsfs_pkg;
  typedef enum logic [3:0] {
    HSFS_OFF,
    HSFS_WAIT_ILK,
    HSFS_INIT_TIME,
    HSFS_WAIT_START,
    HSFS_RUN,
    HSFS_OV_HOLD,
    HSFS_LATCHED,
    HSFS_COOL_DN,
    HSFS_COOL_UP
  } hsfs_state_t;
  typedef logic [`HSFS_MODE_W-1:0] hsfs_mode_t;
endpackage
`default_nettype wire

// >>> rtl/hsfs_pgood.sv
// Power-good latch: sets during start-up on gate-high and output-low.
// Assumes synchronised inputs from the same clock.
`timescale 1ns/100ps
`default_nettype none
module hsfs_pgood (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic startup,
  input wire logic gate_high,
  input wire logic out_low,
  output logic power_ok_flag_n
);
  logic pg_n_r, pg_n_nxt;

  always_comb begin
    pg_n_nxt = pg_n_r;
    if (startup && gate_high && out_low) begin
      pg_n_nxt = 1'b0;
    end
    if (clear) begin
      pg_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pg_n_r <= 1'b1;
    end else begin
      pg_n_r <= pg_n_nxt;
    end
  end

  // Kept at pin polarity so the output leaves a flop; high through reset
  assign power_ok_flag_n = pg_n_r;
endmodule // hsfs_pgood
`default_nettype wire

// >>> rtl/hsfs_seq.sv
// Top of the hot-swap fault sequencer: interlocks, timer mode, gate and ramp control.
// Assumes comparator decisions arrive as asynchronous levels; analog timing
// current and thresholds live in the external circuit this block steers.
`timescale 1ns/100ps
`default_nettype none
`include "hsfs_consts.svh"
module hsfs_seq (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic auto_retry,
  input wire logic supply_lockout_ok,
  input wire logic low_supply_input,
  input wire logic high_supply_input,
  input wire logic breaker_comparator,
  input wire logic ramp_low,
  input wire logic timing_low_cmp,
  input wire logic timing_high_cmp,
  input wire logic gate_low_cmp,
  input wire logic gate_high_cmp,
  input wire logic output_low_cmp,
  input wire logic output_clamp_active,
  output logic gate_enable,
  output logic ramp_release,
  output logic timer_slow_up,
  output logic timer_fast_up,
  output logic timer_slow_down,
  output logic timer_reset,
  output logic clamp_boost_enable,
  output logic power_ok_flag_n,
  output hsfs_pkg::hsfs_state_t seq_state
);
  import hsfs_pkg::*;

  // Limitations: thresholds, currents and hysteresis belong to the analog
  // comparators and sources outside; this block only steers them.
  // Each decision trails its pin by about five clocks, which is small
  // against any timer interval; a glitch sampled on one clock edge only is lost.
  // Trade-off: no digital count of the capacitor, so every interval is set
  // by the external capacitor alone and stays exact whatever the clock.

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  logic [`HSFS_IN_W-1:0] raw_in, syn;
  logic lko, uv_ok, ov, cb, ss_lo, t_lo, t_hi, g_lo, g_hi, d_lo;
  logic uv_prev_r, uv_rise, uv_fall;

  assign raw_in = {supply_lockout_ok, low_supply_input, high_supply_input,
                   breaker_comparator, ramp_low, timing_low_cmp, timing_high_cmp,
                   gate_low_cmp, gate_high_cmp, output_low_cmp};

  hsfs_sync #(.W(`HSFS_IN_W)) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(raw_in),
    .sync_out(syn)
  );

  // Hysteresis of lockout, UV and OV is in the analog comparators
  assign {lko, uv_ok, ov, cb, ss_lo, t_lo, t_hi, g_lo, g_hi, d_lo} = syn;
  assign uv_rise = uv_ok && !uv_prev_r;
  assign uv_fall = !uv_ok && uv_prev_r;

  // Clamp flag passes the same three stages inline; it only gates a current
  logic [2:0] clamp_sh_r;
  logic clamp_r;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  hsfs_state_t state_r, state_nxt;
  logic [2:0] phase_r, phase_nxt;
  logic armed_r, armed_nxt;
  logic [`HSFS_MODE_W-1:0] mode_nxt, mode_r;
  logic gate_nxt, gate_r, ramp_nxt, ramp_r, boost_nxt, boost_r;
  logic pg_clear, pg_start;
  logic start_ilk;
  logic settle_r, settle_nxt;
  logic cb_trip;
  logic [2:0] clamp_sh_nxt;
  logic clamp_nxt;

  // Checks made only before initial timing or ramp-up
  function automatic logic start_checks(input logic cb_i, input logic ss_i,
                                        input logic g_i);
    start_checks = !cb_i && ss_i && g_i;
  endfunction

  assign start_ilk = start_checks(cb, ss_lo, g_lo) && t_lo;

  // On-states: the switch may be driven and breaker timing is live
  function automatic logic on_state(input hsfs_state_t s);
    on_state = (s == HSFS_RUN) || (s == HSFS_OV_HOLD);
  endfunction

  // Right after initial timing the capacitor still sits at the high level
  // until the reset switch has pulled it down; that must not read as a trip
  assign cb_trip = t_hi && !settle_r;

  ////////////////////////////////////////////////////////////////////////
  // Start-up discharge
  // Set on entry to the run state from initial timing, cleared once the timer reads low again
  always_comb begin
    settle_nxt = settle_r;
    if (state_r == HSFS_INIT_TIME && state_nxt == HSFS_RUN) begin
      settle_nxt = 1'b1;
    end else if (t_lo || !on_state(state_nxt)) begin
      settle_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      settle_r <= 1'b0;
    end else begin
      settle_r <= settle_nxt;
    end
  end

  // Clamp flag: shift and agree as in the synchroniser bank, kept apart
  // because it only scales a current and never moves the state
  always_comb begin
    clamp_sh_nxt = {clamp_sh_r[1:0], output_clamp_active};
    clamp_nxt = clamp_r;
    if (clamp_sh_r[1] == clamp_sh_r[2]) begin
      clamp_nxt = clamp_sh_r[2];
    end
  end

  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    armed_nxt = armed_r;
    unique case (state_r)
      HSFS_OFF: begin
        // Leave only with every continuously watched interlock good
        if (lko && uv_ok && !ov) begin
          state_nxt = HSFS_WAIT_ILK;
        end
      end
      HSFS_WAIT_ILK: begin
        // Arm on a UV rise, or when supply came good with UV already high
        if (uv_rise || !armed_r) begin
          armed_nxt = 1'b1;
        end
        if (start_ilk && !ov) begin
          state_nxt = HSFS_INIT_TIME;
        end
      end
      HSFS_INIT_TIME: begin
        // OV throws the partial timing away and starts over
        if (ov) begin
          state_nxt = HSFS_WAIT_ILK;
        end else if (t_hi) begin
          state_nxt = HSFS_RUN;
        end
      end
      HSFS_RUN: begin
        // Breaker timing stays live here; OV only drops the gate and the ramp
        if (ov) begin
          state_nxt = HSFS_OV_HOLD;
        end else if (cb_trip) begin
          state_nxt = auto_retry ? HSFS_COOL_DN : HSFS_LATCHED;
          phase_nxt = '0;
        end
      end
      HSFS_OV_HOLD: begin
        // Timer level not required on recovery
        if (!ov && start_checks(cb, ss_lo, g_lo)) begin
          state_nxt = HSFS_RUN;
        end else if (cb_trip) begin
          // Fault timing ran on through the OV interval
          state_nxt = auto_retry ? HSFS_COOL_DN : HSFS_LATCHED;
          phase_nxt = '0;
        end
      end
      HSFS_LATCHED: begin
        // External pull-low on the timer clears the latch
        if (t_lo) begin
          state_nxt = HSFS_WAIT_ILK;
        end
      end
      HSFS_COOL_DN: begin
        // Last pull-down retries only once the ramp-up checks pass again
        if (t_lo) begin
          if (phase_r + 3'h1 != `HSFS_COOL_DOWN_PHASES) begin
            phase_nxt = phase_r + 3'h1;
            state_nxt = HSFS_COOL_UP;
          end else if (start_checks(cb, ss_lo, g_lo)) begin
            phase_nxt = phase_r + 3'h1;
            state_nxt = HSFS_RUN;
          end
        end
      end
      HSFS_COOL_UP: begin
        // Slow pull-up back to the high level between pull-downs
        if (t_hi) begin
          state_nxt = HSFS_COOL_DN;
        end
      end
      default: state_nxt = HSFS_OFF;
    endcase
    // Lockout and UV act in every state
    if (!lko || !uv_ok || uv_fall) begin
      state_nxt = HSFS_OFF;
      armed_nxt = 1'b0;
      phase_nxt = '0;
    end
  end

  always_comb begin
    gate_nxt = 1'b0;
    ramp_nxt = 1'b0;
    boost_nxt = 1'b0;
    mode_nxt = `HSFS_MODE_RESET;
    unique case (state_nxt)
      HSFS_OFF, HSFS_WAIT_ILK: begin
        mode_nxt = `HSFS_MODE_RESET;
      end
      HSFS_INIT_TIME: begin
        mode_nxt = `HSFS_MODE_SLOW_UP;
      end
      HSFS_RUN, HSFS_OV_HOLD: begin
        gate_nxt = (state_nxt == HSFS_RUN);
        ramp_nxt = (state_nxt == HSFS_RUN);
        if (settle_nxt) begin
          mode_nxt = `HSFS_MODE_RESET;
        end else if (cb) begin
          mode_nxt = `HSFS_MODE_FAST_UP;
          boost_nxt = clamp_r;
        end else begin
          mode_nxt = `HSFS_MODE_SLOW_DN;
        end
      end
      HSFS_LATCHED: begin
        mode_nxt = `HSFS_MODE_SLOW_UP;
      end
      HSFS_COOL_DN: begin
        mode_nxt = `HSFS_MODE_SLOW_DN;
      end
      HSFS_COOL_UP: begin
        mode_nxt = `HSFS_MODE_SLOW_UP;
      end
      default: mode_nxt = `HSFS_MODE_RESET;
    endcase
  end

  // Start-up window for power-good is the run state only; OV leaves it alone
  assign pg_start = (state_r == HSFS_RUN);
  // Clear beats set, so a supply drop never leaves the flag active; the
  // start-up discharge is no timeout and leaves the flag alone
  assign pg_clear = (state_nxt == HSFS_OFF) ||
                    (on_state(state_r) && cb_trip);

  hsfs_pgood u_pgood (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clear(pg_clear),
    .startup(pg_start),
    .gate_high(g_hi),
    .out_low(d_lo),
    .power_ok_flag_n(power_ok_flag_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= HSFS_OFF;
      phase_r <= '0;
      armed_r <= 1'b0;
      mode_r <= `HSFS_MODE_RESET;
      gate_r <= 1'b0;
      ramp_r <= 1'b0;
      boost_r <= 1'b0;
      uv_prev_r <= 1'b0;
      clamp_sh_r <= '0;
      clamp_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      armed_r <= armed_nxt;
      mode_r <= mode_nxt;
      gate_r <= gate_nxt;
      ramp_r <= ramp_nxt;
      boost_r <= boost_nxt;
      uv_prev_r <= uv_ok;
      clamp_sh_r <= clamp_sh_nxt;
      clamp_r <= clamp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Every pin leaves a flop; the timer bits are slices of one mode word,
  // so they switch on the same edge and never overlap
  assign gate_enable = gate_r;
  assign ramp_release = ramp_r;
  assign timer_slow_up = mode_r[0];
  assign timer_fast_up = mode_r[1];
  assign timer_slow_down = mode_r[2];
  assign timer_reset = mode_r[3];
  assign clamp_boost_enable = boost_r;
  assign seq_state = state_r;
endmodule // hsfs_seq
`default_nettype wire

// >>> rtl/hsfs_sync.sv
// Three-stage synchroniser bank for asynchronous comparator levels.
// Assumes inputs are quasi-static logic levels; output moves when stages 2 and 3 agree.
`timescale 1ns/100ps
`default_nettype none
`include "hsfs_consts.svh"
module hsfs_sync #(
  parameter int W = `HSFS_IN_W
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_r, s2_r, s3_r, out_r;
  logic [W-1:0] out_nxt;

  always_comb begin
    // Stage 1 feeds only stage 2; agreement is judged on stages 2 and 3
    out_nxt = out_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        out_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;
endmodule // hsfs_sync
`default_nettype wire

// >>> testbench/hsfs_plant.sv
// Plant model: timing capacitor, switch gate and output node behind the sequencer.
// Assumes one clock of charge per cycle; levels in tenths of a volt.
`timescale 1ns/100ps
`default_nettype none
module hsfs_plant (
  input wire logic ref_clk,
  input wire logic gate_enable,
  input wire logic ramp_release,
  input wire logic slow_up,
  input wire logic fast_up,
  input wire logic slow_down,
  input wire logic t_reset,
  input wire logic boost,
  output logic ramp_low,
  output logic t_lo,
  output logic t_hi,
  output logic g_lo,
  output logic g_hi,
  output logic o_lo
);
  int lvl = 0;
  int gv = 0;
  int n;
  ////////////////////////////////////////////////////////////////////////////////
  // Fast charge kept only a few times slow so a trip stays observable
  always @(posedge ref_clk) begin
    n = lvl + (slow_up ? 1 : 0) + (fast_up ? (boost ? 4 : 2) : 0);
    n = n - ((slow_down && n > 0) ? 1 : 0);
    lvl <= t_reset ? 0 : (n > 48 ? 48 : n);
    gv <= gate_enable ? (gv < 30 ? gv + 1 : gv) : 0;
  end
  assign ramp_low = !ramp_release;
  assign t_lo = lvl < 10;
  assign t_hi = lvl >= 40;
  assign g_lo = gv < 5;
  assign g_hi = gv >= 20;
  assign o_lo = g_hi;
endmodule // hsfs_plant
`default_nettype wire

// >>> testbench/hsfs_seq_chk.sv
// Checker for the sequencer top: interlock, timer mode and power-good relations.
// Assumes comparator pins settle within 8 clocks through the input synchroniser.
`timescale 1ns/100ps
`default_nettype none
module hsfs_seq_chk
  import hsfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic supply_lockout_ok,
  input wire logic low_supply_input,
  input wire logic high_supply_input,
  input wire logic breaker_comparator,
  input wire logic gate_high_cmp,
  input wire logic output_low_cmp,
  input wire logic gate_enable,
  input wire logic ramp_release,
  input wire logic timer_slow_up,
  input wire logic timer_fast_up,
  input wire logic timer_slow_down,
  input wire logic timer_reset,
  input wire logic clamp_boost_enable,
  input wire logic power_ok_flag_n,
  input wire hsfs_pkg::hsfs_state_t seq_state
);
  default clocking dclk @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Repeats of 8 cover the synchroniser plus one register stage
  AST_MODE_ONE: assert property ($onehot({timer_slow_up, timer_fast_up, timer_slow_down,
    timer_reset})) else $error("timer mode not one-hot");
  AST_LOCKOUT: assert property (!supply_lockout_ok [*8] |-> seq_state == HSFS_OFF
    && !gate_enable && timer_reset && power_ok_flag_n) else $error("lockout not obeyed");
  AST_UV_LOW: assert property (!low_supply_input [*8] |-> seq_state == HSFS_OFF
    && !gate_enable && !ramp_release && timer_reset) else $error("undervoltage not obeyed");
  AST_OV_GATE: assert property (high_supply_input [*8] |-> !gate_enable
    && !ramp_release) else $error("gate or ramp up in overvoltage");
  AST_OV_PG: assert property ((high_supply_input && low_supply_input && supply_lockout_ok)
    [*8] |-> $stable(power_ok_flag_n)) else $error("power-good moved in overvoltage");
  AST_CB_UP: assert property ((breaker_comparator && gate_enable) [*8]
    |-> timer_fast_up) else $error("no fast charge on breaker");
  AST_CB_DN: assert property ((!breaker_comparator && gate_enable) [*8]
    |-> timer_slow_down) else $error("no slow discharge without breaker");
  AST_BOOST: assert property (clamp_boost_enable |-> timer_fast_up)
    else $error("boost without fast charge");
  AST_INIT: assert property (seq_state == HSFS_INIT_TIME |-> timer_slow_up
    && !gate_enable && !ramp_release) else $error("initial timing outputs wrong");
  AST_LATCH: assert property (seq_state == HSFS_LATCHED |-> timer_slow_up
    && !gate_enable && !ramp_release) else $error("latched outputs wrong");
  AST_COOL: assert property (seq_state == HSFS_COOL_DN |-> timer_slow_down
    && !gate_enable) else $error("cooling pull-down outputs wrong");
  AST_PG_SET: assert property ($fell(power_ok_flag_n) |-> gate_enable && gate_high_cmp
    && output_low_cmp) else $error("power-good set without cause");
endmodule // hsfs_seq_chk
bind hsfs_seq hsfs_seq_chk u_chk (.ref_clk, .sys_rst, .supply_lockout_ok, .low_supply_input,
  .high_supply_input, .breaker_comparator, .gate_high_cmp, .output_low_cmp, .gate_enable,
  .ramp_release, .timer_slow_up, .timer_fast_up, .timer_slow_down, .timer_reset,
  .clamp_boost_enable, .power_ok_flag_n, .seq_state);
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench: drives comparator levels, plant closes the timer and gate loop.
// Assumes comparator pins reach the sequencer through its synchronisers.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import hsfs_pkg::*;
  logic ref_clk, sys_rst, auto_retry, lko, uv, ov, cb, clamp;
  logic ramp_low, t_lo, t_hi, g_lo, g_hi, o_lo;
  logic gate_en, ramp_rel, s_up, f_up, s_dn, t_rst, boost, pg_n;
  hsfs_state_t st, prev_st;
  hsfs_state_t exp_q[$];
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  hsfs_seq dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .auto_retry(auto_retry),
    .supply_lockout_ok(lko), .low_supply_input(uv), .high_supply_input(ov),
    .breaker_comparator(cb), .ramp_low(ramp_low), .timing_low_cmp(t_lo),
    .timing_high_cmp(t_hi), .gate_low_cmp(g_lo), .gate_high_cmp(g_hi),
    .output_low_cmp(o_lo), .output_clamp_active(clamp), .gate_enable(gate_en),
    .ramp_release(ramp_rel), .timer_slow_up(s_up), .timer_fast_up(f_up),
    .timer_slow_down(s_dn), .timer_reset(t_rst), .clamp_boost_enable(boost),
    .power_ok_flag_n(pg_n), .seq_state(st));
  hsfs_plant plant (.ref_clk(ref_clk), .gate_enable(gate_en), .ramp_release(ramp_rel),
    .slow_up(s_up), .fast_up(f_up), .slow_down(s_dn), .t_reset(t_rst), .boost(boost),
    .ramp_low(ramp_low), .t_lo(t_lo), .t_hi(t_hi), .g_lo(g_lo), .g_hi(g_hi), .o_lo(o_lo));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_state(input hsfs_state_t e, input hsfs_state_t g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR seq_state expected %s seen %s", e.name(), g.name());
    end
  endtask
  // Notes the expected moves, then waits until the monitor has used them all
  task automatic walk(input hsfs_state_t s[$]);
    int n;
    exp_q = {exp_q, s};
    n = 0;
    while (exp_q.size() != 0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 2000) begin
      errors++;
      $display("ERROR seq_state walk expected 0 left seen %0d", exp_q.size());
      exp_q = {};
    end
    repeat (8) @(posedge ref_clk);
  endtask
  // An unnoted move is compared against the old state so it always fails
  always @(posedge ref_clk) begin
    prev_st <= st;
    if (!sys_rst && st !== prev_st) begin
      if (exp_q.size() == 0) chk_state(prev_st, st);
      else chk_state(exp_q.pop_front(), st);
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("ERROR cycle limit expected 5000 seen %0d", cyc);
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    auto_retry = 1'b0;
    lko = 1'b1;
    uv = 1'b1;
    ov = 1'b0;
    cb = 1'b0;
    clamp = 1'b0;
    void'($urandom(32'h2965a95e));
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    walk({HSFS_WAIT_ILK, HSFS_INIT_TIME, HSFS_RUN});
    repeat (40) @(posedge ref_clk);
    chk_bit("power_ok_flag_n", 1'b0, pg_n);
    chk_bit("ramp_release", 1'b1, ramp_rel);
    chk_bit("timer_slow_down", 1'b1, s_dn);
    ov <= 1'b1;
    walk({HSFS_OV_HOLD});
    chk_bit("power_ok_flag_n", 1'b0, pg_n);
    chk_bit("gate_enable", 1'b0, gate_en);
    ov <= 1'b0;
    walk({HSFS_RUN});
    chk_bit("gate_enable", 1'b1, gate_en);
    clamp <= 1'($urandom_range(0, 1));
    cb <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk_bit("timer_fast_up", 1'b1, f_up);
    chk_bit("clamp_boost_enable", clamp, boost);
    walk({HSFS_LATCHED});
    chk_bit("timer_slow_up", 1'b1, s_up);
    chk_bit("power_ok_flag_n", 1'b1, pg_n);
    cb <= 1'b0;
    uv <= 1'b0;
    walk({HSFS_OFF});
    chk_bit("timer_reset", 1'b1, t_rst);
    uv <= 1'b1;
    walk({HSFS_WAIT_ILK, HSFS_INIT_TIME});
    ov <= 1'b1;
    walk({HSFS_WAIT_ILK});
    chk_bit("timer_reset", 1'b1, t_rst);
    ov <= 1'b0;
    walk({HSFS_INIT_TIME, HSFS_RUN});
    lko <= 1'b0;
    walk({HSFS_OFF});
    chk_bit("gate_enable", 1'b0, gate_en);
    lko <= 1'b1;
    walk({HSFS_WAIT_ILK, HSFS_INIT_TIME, HSFS_RUN});
    auto_retry <= 1'b1;
    clamp <= 1'($urandom_range(0, 1));
    cb <= 1'b1;
    walk({HSFS_COOL_DN});
    chk_bit("power_ok_flag_n", 1'b1, pg_n);
    cb <= 1'b0;
    walk({HSFS_COOL_UP, HSFS_COOL_DN, HSFS_COOL_UP, HSFS_COOL_DN, HSFS_COOL_UP, HSFS_COOL_DN,
      HSFS_RUN});
    final_report();
  end
endmodule // testbench
`default_nettype wire
